// File: logic/dpar_top.sv
// doppler velocity pulse counter and gray altitude code reader
//
// Behaviour
// - along pulses count up, 30 per knot-second
// - along channel keeps up with 18000 pulses/s
// - along line is one unsigned channel
// - across pulses scale 85 per knot-second
// - across channel counts correctly to 17000/s
// - across: right line positive, left negative
// - doppler available high means data good
// - altitude sampled when the program requests
// - decoder spans -1000 to +38000 feet
// - code bit 1 means continuity to common
// - ten code bits, 100 ft resolution
// - seven coarse bits: gray, 500 ft steps
// - fine group resolves 100 ft within step
// - zero crossing codes decode to -1, 0, +1
// - works with one or two units paralleled
`timescale 1ns/1ps
`default_nettype none
`include "dpar_consts.svh"
module dpar_top
    import dpar_pkg::*;
#(
    parameter logic [12:0] LINE_GAP_CYC = 13'(`DPAR_LINE_GAP_CYC),
    parameter logic [12:0] CROSS_GAP_CYC = 13'(`DPAR_CROSS_GAP_CYC)
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // doppler radar lines
    input wire logic along_heading_velocity_pulses_i,
    input wire logic across_heading_velocity_pulses_right_i,
    input wire logic across_heading_velocity_pulses_left_i,
    input wire logic doppler_avail_i,
    // velocity snapshot
    input wire logic vel_read_i,
    output dpar_vel_sample_t vel_sample_o,
    output logic vel_valid_o,
    output logic doppler_good_o,
    output logic spacing_err_o,
    // altimeter code, sensed only
    input wire dpar_alt_code_t alt_code_i,
    input wire logic alt_read_i,
    output dpar_alt_word_t alt_o,
    output logic alt_valid_o,
    output logic alt_busy_o
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [6:0] coarse_bin(input dpar_alt_code_t c);
        logic [6:0] g;
        logic [6:0] b;
        g = {c.alt_code_top_bit, c.alt_first_group_weight1, c.alt_first_group_weight2,
             c.alt_first_group_weight4, c.alt_second_group_weight1,
             c.alt_second_group_weight2, c.alt_second_group_weight4};
        b[6] = g[6];
        for (int i = 5; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // position in the five-state fine cycle, reversed in odd coarse steps
    function automatic logic [2:0] fine_idx(input dpar_alt_code_t c, input logic odd);
        logic [2:0] f;
        case ({c.alt_fine_group_weight1, c.alt_fine_group_weight2, c.alt_fine_group_weight4})
            3'h1: f = 3'h0;
            3'h3: f = 3'h1;
            3'h2: f = 3'h2;
            3'h6: f = 3'h3;
            3'h4: f = 3'h4;
            default: f = `DPAR_FINE_BAD;
        endcase
        if (odd && f != `DPAR_FINE_BAD) begin
            f = `DPAR_FINE_STEPS - f;
        end
        return f;
    endfunction

    // ------------------------------------------------------------
    // pulse detection
    // ------------------------------------------------------------
    logic pulse_a;
    logic pulse_r;
    logic pulse_l;

    dpar_pulse_det u_det_along (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .line_i(along_heading_velocity_pulses_i),
        .pulse_o(pulse_a)
    );
    dpar_pulse_det u_det_right (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .line_i(across_heading_velocity_pulses_right_i),
        .pulse_o(pulse_r)
    );
    dpar_pulse_det u_det_left (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .line_i(across_heading_velocity_pulses_left_i),
        .pulse_o(pulse_l)
    );

    // ------------------------------------------------------------
    // velocity accumulation
    // ------------------------------------------------------------
    logic [19:0] along_q;
    logic signed [19:0] across_q;
    logic signed [19:0] across_step;

    // both lines in one cycle cancel out rather than drop one
    assign across_step = 20'(pulse_r) - 20'(pulse_l);

    // pulse in the snapshot cycle lands in the next window, never lost
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            along_q <= `DPAR_CNT_RST;
            across_q <= `DPAR_CNT_RST;
        end else if (vel_read_i) begin
            along_q <= 20'(pulse_a);
            across_q <= across_step;
        end else begin
            along_q <= along_q + 20'(pulse_a);
            across_q <= across_q + across_step;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            vel_sample_o <= '0;
            vel_valid_o <= 1'b0;
            doppler_good_o <= 1'b0;
        end else begin
            if (vel_read_i) begin
                vel_sample_o <= '{along: along_q, across: across_q};
            end
            vel_valid_o <= vel_read_i;
            doppler_good_o <= doppler_avail_i;
        end
    end

    // ------------------------------------------------------------
    // pulse spacing watch
    // ------------------------------------------------------------
    logic [12:0] gap_a_q;
    logic [12:0] gap_d_q;
    logic seen_a_q;
    logic seen_d_q;
    logic last_left_q;
    logic err_a;
    logic err_d;
    logic pulse_d;

    assign pulse_d = pulse_r | pulse_l;
    assign err_a = pulse_a && seen_a_q && (gap_a_q < LINE_GAP_CYC - 13'h0001);
    // sign change needs the wider crosswise gap
    assign err_d = (pulse_r && pulse_l) || (pulse_d && seen_d_q &&
        ((pulse_l != last_left_q) ? (gap_d_q < CROSS_GAP_CYC - 13'h0001)
                                  : (gap_d_q < LINE_GAP_CYC - 13'h0001)));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            gap_a_q <= `DPAR_GAP_RST;
            seen_a_q <= 1'b0;
        end else if (pulse_a) begin
            gap_a_q <= `DPAR_GAP_RST;
            seen_a_q <= 1'b1;
        end else if (gap_a_q != `DPAR_GAP_SAT) begin
            gap_a_q <= gap_a_q + 13'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            gap_d_q <= `DPAR_GAP_RST;
            seen_d_q <= 1'b0;
            last_left_q <= 1'b0;
        end else if (pulse_d) begin
            gap_d_q <= `DPAR_GAP_RST;
            seen_d_q <= 1'b1;
            last_left_q <= pulse_l;
        end else if (gap_d_q != `DPAR_GAP_SAT) begin
            gap_d_q <= gap_d_q + 13'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            spacing_err_o <= 1'b0;
        end else begin
            spacing_err_o <= err_a | err_d;
        end
    end

    // ------------------------------------------------------------
    // altitude read
    // ------------------------------------------------------------
    // inputs are sensed only, so a second unit on the same leads is harmless
    dpar_alt_state_t alt_state_q;
    dpar_alt_code_t code_q;
    logic [6:0] coarse;
    logic [2:0] fine;
    logic [10:0] hund_raw;
    logic signed [10:0] hund;
    logic bad;

    assign coarse = coarse_bin(code_q);
    assign fine = fine_idx(code_q, coarse[0]);
    assign hund_raw = 11'(coarse) * `DPAR_COARSE_STEP_HUND + 11'(fine)
                      - `DPAR_ZERO_OFFSET_HUND;
    assign hund = $signed(hund_raw);
    assign bad = (fine == `DPAR_FINE_BAD) || (hund < `DPAR_ALT_MIN_HUND)
                 || (hund > `DPAR_ALT_MAX_HUND);
    assign alt_busy_o = (alt_state_q != DPAR_ALT_IDLE);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            alt_state_q <= DPAR_ALT_IDLE;
            code_q <= '0;
        end else begin
            case (alt_state_q)
                DPAR_ALT_IDLE: begin
                    if (alt_read_i) begin
                        code_q <= alt_code_i;
                        alt_state_q <= DPAR_ALT_DECODE;
                    end
                end
                DPAR_ALT_DECODE: begin
                    alt_state_q <= DPAR_ALT_IDLE;
                end
                default: begin
                    alt_state_q <= DPAR_ALT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            alt_o <= '0;
            alt_valid_o <= 1'b0;
        end else begin
            alt_valid_o <= (alt_state_q == DPAR_ALT_DECODE);
            if (alt_state_q == DPAR_ALT_DECODE) begin
                alt_o <= '{hundreds: hund, code_err: bad};
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_along_counts_up: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pulse_a && !vel_read_i |=> along_q == $past(along_q) + 20'h00001)
        else $error("along pulse not added");
    a_along_no_sign: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !vel_read_i |=> along_q >= $past(along_q))
        else $error("along count went down");
    a_across_net: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !vel_read_i |=> across_q == $past(across_q) + 20'($past(pulse_r))
                                  - 20'($past(pulse_l)))
        else $error("across count not right minus left");
    a_snapshot_keeps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        vel_read_i |=> vel_valid_o && vel_sample_o.along == $past(along_q)
                       && vel_sample_o.across == $past(across_q))
        else $error("snapshot lost its counts");
    a_doppler_good: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        doppler_avail_i |=> doppler_good_o)
        else $error("doppler good not following discrete");
    a_alt_latency: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        alt_read_i && !alt_busy_o |=> alt_busy_o ##1 (alt_valid_o && !alt_busy_o))
        else $error("altitude not ready two cycles after read");
    a_alt_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        alt_busy_o && code_q == 10'h01A |=> alt_o.hundreds == 11'sh000 && !alt_o.code_err)
        else $error("zero feet code misdecoded");
    a_alt_fine_bad: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        alt_busy_o && fine_idx(code_q, 1'b0) == `DPAR_FINE_BAD |=> alt_o.code_err)
        else $error("illegal fine code accepted");
    a_alt_span: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        alt_valid_o && !alt_o.code_err |-> alt_o.hundreds >= `DPAR_ALT_MIN_HUND
                                           && alt_o.hundreds <= `DPAR_ALT_MAX_HUND)
        else $error("altitude outside span marked good");
    a_gap_flagged: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pulse_r && pulse_l |=> spacing_err_o)
        else $error("coincident across pulses not flagged");

    c_along_pulse: cover property (@(posedge clk_i) disable iff (!rst_n_i) pulse_a);
    c_left_pulse: cover property (@(posedge clk_i) disable iff (!rst_n_i) pulse_l);
    c_alt_good: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        alt_valid_o && !alt_o.code_err);
    c_spacing_err: cover property (@(posedge clk_i) disable iff (!rst_n_i) spacing_err_o);

endmodule // dpar_top
`default_nettype wire

// File: logic/dpar_consts.svh
// constants of the doppler pulse and altitude reader
`ifndef DPAR_CONSTS_SVH
`define DPAR_CONSTS_SVH

// clock rate
`define DPAR_CLK_MHZ 100

// velocity scale: pulses_per_second per knot and top rates
`define DPAR_ALONG_PPS_PER_KNOT 30
`define DPAR_ALONG_MAX_PPS 18000
`define DPAR_ACROSS_PPS_PER_KNOT 85
`define DPAR_ACROSS_MAX_PPS 17000

// least pulse spacing the radar keeps, in microseconds and cycles
`define DPAR_LINE_GAP_US 40
`define DPAR_CROSS_GAP_US 45
`define DPAR_LINE_GAP_CYC (`DPAR_LINE_GAP_US * `DPAR_CLK_MHZ)
`define DPAR_CROSS_GAP_CYC (`DPAR_CROSS_GAP_US * `DPAR_CLK_MHZ)

// altitude arithmetic in 100 ft units
`define DPAR_COARSE_STEP_HUND 11'h005
`define DPAR_ZERO_OFFSET_HUND 11'h00C
`define DPAR_ALT_MIN_HUND (-11'sh00A)
`define DPAR_ALT_MAX_HUND 11'sh17C
`define DPAR_FINE_STEPS 3'h4
`define DPAR_FINE_BAD 3'h7

// counter reset values and gap counter saturation value
`define DPAR_CNT_RST 20'h00000
`define DPAR_GAP_RST 13'h0000
`define DPAR_GAP_SAT 13'h1FFF

`endif

// File: logic/dpar_pkg.sv
// types of the doppler pulse and altitude reader
package dpar_pkg;

    // parallel altitude code, 1 = lead shows continuity to common
    typedef struct packed {
        logic alt_code_top_bit;
        logic alt_first_group_weight1;
        logic alt_first_group_weight2;
        logic alt_first_group_weight4;
        logic alt_second_group_weight1;
        logic alt_second_group_weight2;
        logic alt_second_group_weight4;
        logic alt_fine_group_weight1;
        logic alt_fine_group_weight2;
        logic alt_fine_group_weight4;
    } dpar_alt_code_t;

    // velocity increments since the previous snapshot
    typedef struct packed {
        logic [19:0] along;
        logic signed [19:0] across;
    } dpar_vel_sample_t;

    // decoded altitude
    typedef struct packed {
        logic signed [10:0] hundreds;
        logic code_err;
    } dpar_alt_word_t;

    typedef enum logic {DPAR_ALT_IDLE, DPAR_ALT_DECODE} dpar_alt_state_t;

endpackage

// File: logic/dpar_pulse_det.sv
// pulse line synchroniser and rising edge detector
`timescale 1ns/1ps
`default_nettype none
module dpar_pulse_det (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // pulse line and one count per pulse
    input wire logic line_i,
    output logic pulse_o
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;

    // ------------------------------------------------------------
    // synchroniser, first stage read only by the second
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= line_i;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // one count per pulse edge; 5 us pulses span hundreds of cycles
    assign pulse_o = sync2_q & ~prev_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_edge_to_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(line_i) ##1 line_i |-> ##1 pulse_o)
        else $error("pulse edge not counted two cycles later");
    a_single_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pulse_o |=> !pulse_o)
        else $error("one pulse counted twice");

endmodule // dpar_pulse_det
`default_nettype wire

// File: sim/dpar_sensor_model.sv
// behavioural doppler radar and encoding altimeter
`timescale 1ns/1ps
`default_nettype none
module dpar_sensor_model
    import dpar_pkg::*;
(
    // clock
    input wire logic clk_i,
    // radar lines
    output logic along_o,
    output logic right_o,
    output logic left_o,
    output logic avail_o,
    // altimeter leads
    output dpar_alt_code_t alt_code_o
);
    // lines idle low; open leads read as 0
    initial begin
        along_o = 1'b0;
        right_o = 1'b0;
        left_o = 1'b0;
        avail_o = 1'b0;
        alt_code_o = '0;
    end

    // one 3 cycle pulse, then quiet so edges are gap cycles apart
    // along has one line and no sign; across has right and left
    task automatic pulse(input int line, input int gap);
        case (line)
            0: along_o = 1'b1;
            1: right_o = 1'b1;
            default: left_o = 1'b1;
        endcase
        repeat (3) @(posedge clk_i);
        #1;
        along_o = 1'b0;
        right_o = 1'b0;
        left_o = 1'b0;
        repeat (gap - 3) @(posedge clk_i);
        #1;
    endtask

    task automatic set_alt(input dpar_alt_code_t c);
        alt_code_o = c;
    endtask

    task automatic set_avail(input logic v);
        avail_o = v;
    endtask
endmodule // dpar_sensor_model
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench of the doppler pulse and altitude reader
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dpar_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic rst_n_i;
    logic vel_read_i;
    logic alt_read_i;
    logic along, right, left, avail;
    dpar_alt_code_t alt_code;
    dpar_vel_sample_t vel_sample_o;
    logic vel_valid_o, doppler_good_o, spacing_err_o;
    dpar_alt_word_t alt_o;
    logic alt_valid_o, alt_busy_o;
    int mismatches = 0;
    int n_compared = 0;
    int n_space = 0;

    always #5 clk_i = ~clk_i;

    dpar_sensor_model mdl (
        .clk_i(clk_i), .along_o(along), .right_o(right), .left_o(left),
        .avail_o(avail), .alt_code_o(alt_code)
    );

    // short gaps keep the run brief
    dpar_top #(.LINE_GAP_CYC(13'h0028), .CROSS_GAP_CYC(13'h002D)) DUT (
        .clk_i(clk_i), .rst_n_i(rst_n_i),
        .along_heading_velocity_pulses_i(along),
        .across_heading_velocity_pulses_right_i(right),
        .across_heading_velocity_pulses_left_i(left),
        .doppler_avail_i(avail), .vel_read_i(vel_read_i),
        .vel_sample_o(vel_sample_o), .vel_valid_o(vel_valid_o),
        .doppler_good_o(doppler_good_o), .spacing_err_o(spacing_err_o),
        .alt_code_i(alt_code), .alt_read_i(alt_read_i), .alt_o(alt_o),
        .alt_valid_o(alt_valid_o), .alt_busy_o(alt_busy_o)
    );

    // spacing flags are one cycle wide, so count them as they pass
    always @(posedge clk_i) begin
        if (spacing_err_o === 1'b1) begin
            n_space++;
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // settle, take a snapshot and judge it
    task automatic snap(input logic [39:0] exp);
        repeat (5) tick();
        vel_read_i = 1'b1;
        tick();
        vel_read_i = 1'b0;
        check(40'(vel_valid_o), 40'h1);
        check(vel_sample_o, exp);
        tick();
        check(40'(vel_valid_o), 40'h0);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        check(40'({vel_valid_o, alt_valid_o, alt_busy_o, spacing_err_o}), 40'h0);
        check(vel_sample_o, 40'h0);
    endtask

    // five along pulses at the tightest legal spacing
    task automatic t_along();
        repeat (5) mdl.pulse(0, 40);
        snap({20'h00005, 20'h00000});
        snap({20'h00000, 20'h00000});
        check(40'(n_space), 40'h0);
    endtask

    // three right minus two left, sign change at 45 cycles
    task automatic t_across();
        repeat (3) mdl.pulse(1, 45);
        repeat (2) mdl.pulse(2, 45);
        snap({20'h00000, 20'h00001});
        check(40'(n_space), 40'h0);
    endtask

    // too close pulses are flagged but still counted
    task automatic t_spacing();
        mdl.pulse(0, 20);
        mdl.pulse(0, 60);
        check(40'(n_space), 40'h1);
        mdl.pulse(1, 40);
        mdl.pulse(2, 60);
        check(40'(n_space), 40'h2);
        snap({20'h00002, 20'h00000});
    endtask

    task automatic t_avail();
        mdl.set_avail(1'b1);
        tick();
        check(40'(doppler_good_o), 40'h1);
        mdl.set_avail(1'b0);
        tick();
        check(40'(doppler_good_o), 40'h0);
    endtask

    // code is taken at the request edge, then the leads change
    // err_only: result field of a broken code is undefined, judge the flag alone
    task automatic alt_case(input logic [9:0] code, input logic [11:0] exp,
                            input logic err_only);
        mdl.set_alt(code);
        alt_read_i = 1'b1;
        tick();
        alt_read_i = 1'b0;
        mdl.set_alt(~code);
        check(40'({alt_busy_o, alt_valid_o}), 40'h2);
        tick();
        check(40'({alt_busy_o, alt_valid_o}), 40'h1);
        if (err_only) begin
            check(40'(alt_o.code_err), 40'h1);
        end else begin
            check(40'(alt_o), 40'(exp));
        end
    endtask

    // odd coarse step runs the fine cycle backwards; 388 lies above the span
    task automatic t_alt();
        alt_case(10'h01B, {-11'sh001, 1'b0}, 1'b0);
        alt_case(10'h01A, {11'h000, 1'b0}, 1'b0);
        alt_case(10'h01E, {11'h001, 1'b0}, 1'b0);
        alt_case(10'h002, {-11'sh00A, 1'b0}, 1'b0);
        alt_case(10'h34A, {11'h17C, 1'b0}, 1'b0);
        alt_case(10'h3C1, {11'h184, 1'b1}, 1'b0);
        alt_case(10'h011, {11'h007, 1'b0}, 1'b0);
        alt_case(10'h0C8, {11'h000, 1'b1}, 1'b1);
    endtask

    // a request during busy is ignored
    task automatic t_alt_busy();
        tick();
        mdl.set_alt(10'h01A);
        alt_read_i = 1'b1;
        tick();
        mdl.set_alt(10'h01E);
        tick();
        alt_read_i = 1'b0;
        check(40'(alt_valid_o), 40'h1);
        check(40'(alt_o), 40'h0);
        tick();
        check(40'({alt_busy_o, alt_valid_o}), 40'h0);
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        rst_n_i = 1'b0;
        vel_read_i = 1'b0;
        alt_read_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        t_reset();
        rst_n_i = 1'b1;
        tick();
        t_along();
        t_across();
        t_spacing();
        t_avail();
        t_alt();
        t_alt_busy();
        wrap_up();
    end

    // the tests take about 660 cycles
    initial begin
        #50000;
        mismatches++;
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
